// ### rtl/loop_params.svh
/*
  Offsets, field positions, reset values and timing counts for the port
  loopback control block.
  Assumes it is included by bare name after any timescale directive.
*/
`ifndef LOOP_PARAMS_SVH
`define LOOP_PARAMS_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define ADDR_PORT_MODE 8'h04
`define ADDR_TX_CELL_INT_EN 8'h28
`define ADDR_FRAMER_MODE 8'h30
`define ADDR_FRAMER_FEATURE 8'h34
`define ADDR_LOOP_STATUS 8'h38

// ****************************************************************
// Field positions
// ****************************************************************
`define PM_CD_SRC_LOOP 5
`define PM_FAR_END_LOOP 6
`define CE_SOC_ERR_INT 6
`define FM_SHALLOW 0
`define FM_SOURCE 1
`define FM_ALARM_LO 2
`define FM_ALARM_HI 3
`define FF_UNIPOLAR 0
`define FF_FORCE_ZEROS 1
`define FF_RX_ALL_ONES 2
`define FF_RX_AIS 3
`define FF_REMOTE 4
`define FF_PAYLOAD 5
`define FF_ERR_INSERT 6

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define REG_RESET 8'h00
`define CLK_PERIOD_NS 50
`define LINE_CLK_PERIOD_NS 400
`define SETTLE_SLOW_CYCLES 20
// Least time, so round up to whole system cycles
`define SETTLE_CYCLES ((`SETTLE_SLOW_CYCLES * `LINE_CLK_PERIOD_NS + \
  `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### rtl/loop_pkg.sv
/*
  Types shared by the port loopback control block.
  Assumes nothing of its surroundings.
*/
package loop_pkg;

  typedef enum logic [1:0] {
    ALM_NONE = 2'h0,
    ALM_AIS = 2'h1,
    ALM_IDLE = 2'h2,
    ALM_RAI = 2'h3
  } tx_alarm_t;

  typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;

  typedef logic [7:0] reg_byte_t;

endpackage

// ### rtl/sync_2ff.sv
/*
  Two flip-flop synchroniser for a group of independent level signals.
  Assumes each bit is a level from outside the clock's domain.
*/
`timescale 1ns/1ps

module sync_2ff #(
  parameter int WIDTH = 1
) (
  input wire logic clock, // sampling clock
  input wire logic rst, // asynchronous reset, active high
  input wire logic [WIDTH-1:0] async, // signals from outside
  output logic [WIDTH-1:0] synced // second stage
);

  logic [WIDTH-1:0] stage_reg;

  // First stage feeds only the second
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage_reg <= '0;
      synced <= '0;
    end else begin
      stage_reg <= async;
      synced <= stage_reg;
    end
  end

endmodule

// ### rtl/port_loopback_control.sv
/*
  Loopback steering for one framer port with its cell delineator,
  reached over an Avalon-MM slave with waitrequest.
  Assumes line clocks and receive rails are asynchronous pins; all
  core-side streams run on clock.
*/
`timescale 1ns/1ps
`include "loop_params.svh"

// ****************************************************************
// Behaviour
// - Port mode bit 5 loops transmitted cells back
// - Cell source loop ignores framer receive data
// - Far-end loop turns received cells around
// - Shallow loop sends raw rails back out
// - Receive data still delivered, override allowed
// - Receive clock drives transmitter, outputs quiet
// - Error insertion off in shallow and remote loops and in source loop with AIS or force-zeros
// - Force-zeros blanks the transmit rails
// - Unipolar shallow loop drives negative rail low
// - Remote loop feeds decoder into encoder
// - Remote loop AIS unaligned, idle/RAI off
// - Payload loop generates overhead internally
// - Payload loop takes frame and alignment
// - Payload loop alarms aligned as normal
// - Source loop feeds encoder into decoder
// - Source loop AIS touches rails only, idle/RAI go to core
// - Separate enable bits for each loop
// - Transmit cell interrupt enables at 0x28
// ****************************************************************

module port_loopback_control (
  input wire logic clock, // system clock, 20 MHz
  input wire logic rst, // asynchronous reset, active high
  input wire logic [7:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic rxLineClockIn, // receive line clock pin
  input wire logic txLineClockIn, // transmit line clock pin
  input wire logic rxPosRailIn, // positive receive rail pin
  input wire logic rxNegRailIn, // negative receive rail pin
  output logic txPosRailOut, // positive transmit rail
  output logic txNegRailOut, // negative transmit rail
  input wire logic encPos, // encoder positive output
  input wire logic encNeg, // encoder negative output
  input wire logic aisPos, // unaligned AIS line pattern
  input wire logic aisNeg, // unaligned AIS line pattern
  input wire logic decodedData, // bipolar decoder output
  input wire logic frameGenData, // frame generator output
  input wire logic txDataIn, // system transmit data
  input wire logic recoveredData, // frame recovery output
  input wire logic recoveredFrameStart, // receiver alignment
  input wire logic txGenFrameStart, // own frame alignment
  input wire logic rxFramerData, // receive data to system
  input wire logic rxAisBit, // AIS stream for receive output
  input wire logic coreGappedClock, // core transmit clock
  input wire logic coreOverheadClock, // core overhead clock
  input wire logic coreFrameSync, // core transmit sync
  output logic decoderPosIn, // decoder positive input
  output logic decoderNegIn, // decoder negative input
  output logic encoderDataIn, // encoder input
  output logic frameGenDataIn, // frame generator input
  output logic frameGenSyncIn, // frame generator alignment
  output logic overheadExternalEn, // take external overhead
  output logic txClockFromRx, // transmitter on rx clock
  output logic txGappedClockOut, // system transmit clock
  output logic txOverheadClockOut, // overhead clock
  output logic txFrameSync, // transmit sync
  output logic rxDataOut, // receive data output
  output logic errInsertEn, // error insertion allowed
  output loop_pkg::tx_alarm_t txAlarmCmd, // alarm to core
  output logic startOfCellErrIntEn, // start-of-cell int en
  input wire logic [7:0] cdTxByte, // cells toward framer
  input wire logic cdTxValid, // cells toward framer valid
  input wire logic [7:0] framerRxByte, // cells from framer
  input wire logic framerRxValid, // from framer valid
  input wire logic [7:0] rxCellByte, // received cells
  input wire logic rxCellValid, // received cells valid
  input wire logic [7:0] busTxByte, // cells from cell bus
  input wire logic busTxValid, // from cell bus valid
  output logic [7:0] cdRxByte, // into receive line side
  output logic cdRxValid, // into receive line valid
  output logic [7:0] cellTxByte, // into cell transmit block
  output logic cellTxValid, // into cell transmit valid
  output logic [7:0] busRxByte, // toward cell bus
  output logic busRxValid // toward cell bus valid
);

  import loop_pkg::*;

  localparam logic [7:0] SETTLE_COUNT = 8'(`SETTLE_CYCLES);

  reg_byte_t portMode_reg;
  reg_byte_t txCellIntEn_reg;
  reg_byte_t framerMode_reg;
  reg_byte_t framerFeature_reg;
  bus_state_t busState_reg;
  logic [7:0] settleCnt_reg;
  reg_byte_t readByte;
  logic request;
  logic commitWrite;

  // ****************************************************************
  // Register bus slave
  // ****************************************************************
  assign request = avs_read | avs_write;
  assign commitWrite = (busState_reg == BUS_ACK) && avs_write;

  always_comb begin
    readByte = 8'h00;
    case (avs_address)
      `ADDR_PORT_MODE: readByte = portMode_reg;
      `ADDR_TX_CELL_INT_EN: readByte = txCellIntEn_reg;
      `ADDR_FRAMER_MODE: readByte = framerMode_reg;
      `ADDR_FRAMER_FEATURE: readByte = framerFeature_reg;
      `ADDR_LOOP_STATUS: readByte = {1'b0, portMode_reg[`PM_FAR_END_LOOP],
        portMode_reg[`PM_CD_SRC_LOOP], framerMode_reg[`FM_SOURCE],
        framerFeature_reg[`FF_PAYLOAD], framerFeature_reg[`FF_REMOTE],
        framerMode_reg[`FM_SHALLOW], settleCnt_reg != 8'h00};
      default: readByte = 8'h00;
    endcase
  end

  // settle stall
  // Requests are held off while clocks switch rather than trusted
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busState_reg <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      unique case (busState_reg)
        BUS_IDLE: begin
          if (request && settleCnt_reg == 8'h00) begin
            busState_reg <= BUS_ACK;
            avs_waitrequest <= 1'b0;
            avs_readdata <= {24'h00_0000, readByte};
          end
        end
        BUS_ACK: begin
          busState_reg <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      settleCnt_reg <= 8'h00;
    end else if (commitWrite && (avs_address == `ADDR_FRAMER_MODE ||
        avs_address == `ADDR_FRAMER_FEATURE)) begin
      settleCnt_reg <= SETTLE_COUNT;
    end else if (settleCnt_reg != 8'h00) begin
      settleCnt_reg <= settleCnt_reg - 8'h01;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      portMode_reg <= `REG_RESET;
      txCellIntEn_reg <= `REG_RESET;
      framerMode_reg <= `REG_RESET;
      framerFeature_reg <= `REG_RESET;
    end else if (commitWrite) begin
      case (avs_address)
        `ADDR_PORT_MODE: portMode_reg <= avs_writedata[7:0];
        `ADDR_TX_CELL_INT_EN: txCellIntEn_reg <= avs_writedata[7:0];
        `ADDR_FRAMER_MODE: framerMode_reg <= avs_writedata[7:0];
        `ADDR_FRAMER_FEATURE: framerFeature_reg <= avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  logic cdSrcLoop, farEndLoop, shallow, framerSrc, remote, payload;
  logic rxClocked, forceZeros, unipolar, aisOnRails, errAllowed;
  tx_alarm_t alarm;
  assign cdSrcLoop = portMode_reg[`PM_CD_SRC_LOOP];
  assign farEndLoop = portMode_reg[`PM_FAR_END_LOOP];
  assign shallow = framerMode_reg[`FM_SHALLOW];
  assign framerSrc = framerMode_reg[`FM_SOURCE];
  assign alarm = tx_alarm_t'(framerMode_reg[`FM_ALARM_HI:`FM_ALARM_LO]);
  assign remote = framerFeature_reg[`FF_REMOTE];
  assign payload = framerFeature_reg[`FF_PAYLOAD];
  assign forceZeros = framerFeature_reg[`FF_FORCE_ZEROS];
  assign unipolar = framerFeature_reg[`FF_UNIPOLAR];
  assign rxClocked = shallow | remote | payload;
  assign aisOnRails = (remote | framerSrc) && alarm == ALM_AIS;
  assign errAllowed = framerFeature_reg[`FF_ERR_INSERT] && !shallow &&
    !remote && !(framerSrc && (aisOnRails || forceZeros));

  // ****************************************************************
  // Line pin sampling
  // ****************************************************************
  logic [3:0] pinSync;
  logic rxClkPrev_reg, txClkPrev_reg, rxEdge, txEdge;

  sync_2ff #(.WIDTH(4)) pinSampler (
    .clock(clock),
    .rst(rst),
    .async({rxNegRailIn, rxPosRailIn, txLineClockIn, rxLineClockIn}),
    .synced(pinSync)
  );

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rxClkPrev_reg <= 1'b0;
      txClkPrev_reg <= 1'b0;
    end else begin
      rxClkPrev_reg <= pinSync[0];
      txClkPrev_reg <= pinSync[1];
    end
  end
  assign rxEdge = pinSync[0] & ~rxClkPrev_reg;
  assign txEdge = rxClocked ? rxEdge : (pinSync[1] & ~txClkPrev_reg);

  // ****************************************************************
  // Transmit rails
  // ****************************************************************
  // raw rails looped
  // force-zeros wins over shallow if software sets both
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      txPosRailOut <= 1'b0;
      txNegRailOut <= 1'b0;
    end else if (txEdge) begin
      if (forceZeros) begin
        txPosRailOut <= 1'b0;
        txNegRailOut <= 1'b0;
      end else if (shallow) begin
        txPosRailOut <= pinSync[2];
        txNegRailOut <= unipolar ? 1'b0 : pinSync[3];
      end else if (aisOnRails) begin
        txPosRailOut <= aisPos;
        txNegRailOut <= aisNeg;
      end else begin
        txPosRailOut <= encPos;
        txNegRailOut <= encNeg;
      end
    end
  end

  // ****************************************************************
  // Framer core steering
  // ****************************************************************
  // decoder into encoder
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      decoderPosIn <= 1'b0;
      decoderNegIn <= 1'b0;
      encoderDataIn <= 1'b0;
      frameGenDataIn <= 1'b0;
      frameGenSyncIn <= 1'b0;
      overheadExternalEn <= 1'b1;
      txAlarmCmd <= ALM_NONE;
    end else begin
      decoderPosIn <= framerSrc ? encPos : pinSync[2];
      decoderNegIn <= framerSrc ? encNeg : pinSync[3];
      encoderDataIn <= remote ? decodedData : frameGenData;
      frameGenDataIn <= payload ? recoveredData : txDataIn;
      frameGenSyncIn <= payload ? recoveredFrameStart : txGenFrameStart;
      overheadExternalEn <= !payload;
      // Remote loop: AIS is done on the rails, idle and RAI dropped
      // Source loop: AIS stays off the looped frame
      if (remote || (framerSrc && alarm == ALM_AIS)) begin
        txAlarmCmd <= ALM_NONE;
      end else begin
        txAlarmCmd <= alarm;
      end
    end
  end

  // receiver alarms not acted on here
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rxDataOut <= 1'b0;
      txClockFromRx <= 1'b0;
      txGappedClockOut <= 1'b0;
      txOverheadClockOut <= 1'b0;
      txFrameSync <= 1'b0;
      errInsertEn <= 1'b0;
    end else begin
      if (framerFeature_reg[`FF_RX_ALL_ONES]) begin
        rxDataOut <= 1'b1;
      end else if (framerFeature_reg[`FF_RX_AIS]) begin
        rxDataOut <= rxAisBit;
      end else begin
        rxDataOut <= rxFramerData;
      end
      txClockFromRx <= rxClocked;
      txGappedClockOut <= !rxClocked && coreGappedClock;
      txOverheadClockOut <= !rxClocked && coreOverheadClock;
      txFrameSync <= !rxClocked && coreFrameSync;
      errInsertEn <= errAllowed;
    end
  end

  // ****************************************************************
  // Cell delineator steering
  // ****************************************************************
  // transmitted cells looped
  // looped cells need no line clocks running
  // enable stays as software leaves it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cdRxByte <= 8'h00;
      cdRxValid <= 1'b0;
      cellTxByte <= 8'h00;
      cellTxValid <= 1'b0;
      busRxByte <= 8'h00;
      busRxValid <= 1'b0;
      startOfCellErrIntEn <= 1'b0;
    end else begin
      cdRxByte <= cdSrcLoop ? cdTxByte : framerRxByte;
      cdRxValid <= cdSrcLoop ? cdTxValid : framerRxValid;
      cellTxByte <= farEndLoop ? rxCellByte : busTxByte;
      cellTxValid <= farEndLoop ? rxCellValid : busTxValid;
      busRxByte <= farEndLoop ? 8'h00 : rxCellByte;
      busRxValid <= !farEndLoop && rxCellValid;
      startOfCellErrIntEn <= txCellIntEn_reg[`CE_SOC_ERR_INT];
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  cd_src_loop_a: assert property (
    $past(cdSrcLoop) |-> cdRxValid == $past(cdTxValid) &&
      cdRxByte == $past(cdTxByte))
    else $error("cell source loop not returning transmit cells");

  framer_ignored_a: assert property (
    $past(cdSrcLoop) && !$past(cdTxValid) |-> !cdRxValid)
    else $error("framer cells leaked during source loop");

  far_end_loop_a: assert property (
    $past(farEndLoop) |-> !busRxValid &&
      cellTxValid == $past(rxCellValid))
    else $error("far-end loop path wrong");

  shallow_rails_a: assert property (
    $past(shallow && !forceZeros && txEdge) |->
      txPosRailOut == $past(pinSync[2]) &&
      txNegRailOut == ($past(unipolar) ? 1'b0 : $past(pinSync[3])))
    else $error("shallow loop rails not raw receive rails");

  force_zeros_a: assert property (
    $past(forceZeros && txEdge) |-> !txPosRailOut && !txNegRailOut)
    else $error("force-zeros did not blank rails");

  quiet_clocks_a: assert property (
    $past(rxClocked) |-> txClockFromRx && !txGappedClockOut &&
      !txOverheadClockOut && !txFrameSync)
    else $error("transmit clocks active in receive-clocked loop");

  err_insert_a: assert property (
    $past(shallow || remote) |-> !errInsertEn)
    else $error("error insertion allowed in line loop");

  src_decoder_a: assert property (
    $past(framerSrc) |-> decoderPosIn == $past(encPos) &&
      decoderNegIn == $past(encNeg))
    else $error("source loop decoder input wrong");

  payload_path_a: assert property (
    $past(payload) |-> frameGenDataIn == $past(recoveredData) &&
      frameGenSyncIn == $past(recoveredFrameStart) &&
      !overheadExternalEn)
    else $error("payload loop path wrong");

  settle_stall_a: assert property (
    commitWrite && avs_address == `ADDR_FRAMER_MODE |=>
      avs_waitrequest [*8])
    else $error("access answered while clocks settle");

  shallow_cov: cover property ($rose(shallow) ##[1:40] txEdge);
  payload_alarm_cov: cover property (payload && alarm == ALM_AIS);
  settle_done_cov: cover property ($fell(settleCnt_reg != 8'h00));
  read_ack_cov: cover property (avs_read && !avs_waitrequest);

endmodule

// ### tb/cell_host_model.sv
/*
  Behavioural cell bus host facing the block's cell bus ports.
  Assumes clock and an active high rst shared with the block.
*/
`timescale 1ns/1ps

module cell_host_model (
  input wire logic clock, // system clock
  input wire logic rst, // reset, active high
  input wire logic slow, // offer a byte every other cycle
  input wire logic [7:0] busRxByte, // cells from the block
  input wire logic busRxValid, // cells from the block valid
  output logic [7:0] busTxByte, // cells toward the block
  output logic busTxValid // cells toward the block valid
);
  logic [7:0] countReg;
  logic [15:0] seenReg;
  logic offer;

  assign offer = !slow || !busTxValid;

  // Idle byte is inverted so stale data never passes for a cell
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      countReg <= 8'h00;
      busTxValid <= 1'b0;
      busTxByte <= 8'h00;
    end else begin
      busTxValid <= offer;
      countReg <= countReg + 8'h01;
      busTxByte <= offer ? countReg : ~busTxByte;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      seenReg <= 16'h0000;
    end else if (busRxValid) begin
      seenReg <= seenReg + {8'h00, busRxByte} + 16'h0001;
    end
  end
endmodule

// ### tb/test_port_loopback_control.sv
/*
  Self-checking bench for the port loopback control block.
  Assumes the block's package and parameter header are compiled first.
*/
`timescale 1ns/1ps
`include "loop_params.svh"

module test_port_loopback_control;
  import loop_pkg::*;
  typedef logic [43:0] obs_t;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic rxLineClockIn = 1'b0;
  logic txLineClockIn = 1'b0;
  logic rxPosRailIn = 1'b0;
  logic rxNegRailIn = 1'b0;
  logic [14:0] core = 15'h0;
  logic [8:0] cdTx = 9'h0, frRx = 9'h0, rxCell = 9'h0;
  logic txPosRailOut, txNegRailOut, decoderPosIn, decoderNegIn;
  logic encoderDataIn, frameGenDataIn, frameGenSyncIn, overheadExternalEn;
  logic txClockFromRx, txGappedClockOut, txOverheadClockOut, txFrameSync;
  logic rxDataOut, errInsertEn, startOfCellErrIntEn;
  tx_alarm_t txAlarmCmd;
  logic [7:0] cdRxByte, cellTxByte, busRxByte, busTxByte;
  logic cdRxValid, cellTxValid, busRxValid, busTxValid;
  logic slow = 1'b0;
  logic streamOn = 1'b0;
  logic [7:0] pm = 8'h00, ce = 8'h00, fm = 8'h00, ff = 8'h00, rd;
  logic [87:0] expQ [$];
  int seed = 28871;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  int lat;
  logic [31:0] cfgTab [12] = '{32'h00400040, 32'h20400040, 32'h40000000,
    32'h00400145, 32'h00400148, 32'h00400450, 32'h00400c50, 32'h00400860,
    32'h00400640, 32'h00400e42, 32'h00000000, 32'h00400462};
  logic [7:0] regAddr [6] = '{8'h04, 8'h28, 8'h30, 8'h34, 8'h38, 8'h10};

  always #25 clock = ~clock;
  always #200 rxLineClockIn = ~rxLineClockIn;
  initial #37 forever #200 txLineClockIn = ~txLineClockIn;

  port_loopback_control uut (.clock, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .rxLineClockIn, .txLineClockIn, .rxPosRailIn, .rxNegRailIn,
    .txPosRailOut, .txNegRailOut, .encPos(core[0]), .encNeg(core[1]),
    .aisPos(core[2]), .aisNeg(core[3]), .decodedData(core[4]),
    .frameGenData(core[5]), .txDataIn(core[6]), .recoveredData(core[7]),
    .recoveredFrameStart(core[8]), .txGenFrameStart(core[9]),
    .rxFramerData(core[10]), .rxAisBit(core[11]),
    .coreGappedClock(core[12]), .coreOverheadClock(core[13]),
    .coreFrameSync(core[14]), .decoderPosIn, .decoderNegIn, .encoderDataIn,
    .frameGenDataIn, .frameGenSyncIn, .overheadExternalEn, .txClockFromRx,
    .txGappedClockOut, .txOverheadClockOut, .txFrameSync, .rxDataOut,
    .errInsertEn, .txAlarmCmd, .startOfCellErrIntEn,
    .cdTxByte(cdTx[7:0]), .cdTxValid(cdTx[8]), .framerRxByte(frRx[7:0]),
    .framerRxValid(frRx[8]), .rxCellByte(rxCell[7:0]),
    .rxCellValid(rxCell[8]), .busTxByte, .busTxValid, .cdRxByte, .cdRxValid,
    .cellTxByte, .cellTxValid, .busRxByte, .busRxValid);

  cell_host_model host (.clock, .rst, .slow, .busRxByte, .busRxValid,
    .busTxByte, .busTxValid);

  // ****************************************************************
  // Stimulus, expectations and comparison
  // ****************************************************************
  always @(posedge clock) begin
    core <= 15'($random(seed));
    cdTx <= 9'($random(seed));
    frRx <= 9'($random(seed));
    rxCell <= 9'($random(seed));
  end

  function automatic logic [87:0] expect_obs();
    logic sh, rm, pl, sc, lp;
    logic [1:0] a;
    obs_t v, m;
    sh = fm[0];
    sc = fm[1];
    a = fm[3:2];
    rm = ff[4];
    pl = ff[5];
    lp = sh | rm | pl;
    m = '1;
    v[8:0] = pm[5] ? cdTx : frRx;
    v[17:9] = pm[6] ? rxCell : {busTxValid, busTxByte};
    v[26:18] = pm[6] ? 9'h0 : rxCell;
    m[7:0] = {8{v[8]}};
    m[16:9] = {8{v[17]}};
    m[25:18] = {8{v[26]}};
    v[30:27] = {lp ? 3'h0 : core[14:12], lp};
    v[31] = ff[6] && !sh && !rm && !(sc && (a == 2'h1 || ff[1]));
    v[32] = !pl;
    v[33] = pl ? core[8] : core[9];
    v[34] = rm ? core[4] : core[5];
    m[34] = !sh;
    v[35] = ff[2] ? 1'b1 : (ff[3] ? core[11] : core[10]);
    v[37:36] = (rm || (sc && a == 2'h1)) ? 2'h0 : a;
    v[39:38] = sc ? {core[0], core[1]} : {rxPosRailIn, rxNegRailIn};
    v[41:40] = ff[1] ? 2'h0 : {rxPosRailIn, rxNegRailIn & !ff[0]};
    m[41:40] = {2{ff[1] | sh}};
    v[42] = ce[6];
    v[43] = pl ? core[7] : core[6];
    return {m, v};
  endfunction

  always @(posedge clock) begin
    if (streamOn) expQ.push_back(expect_obs());
  end

  always @(negedge clock) begin
    obs_t act;
    logic [87:0] e;
    if (expQ.size() > 0) begin
      e = expQ.pop_front();
      act = {frameGenDataIn, startOfCellErrIntEn, txPosRailOut,
        txNegRailOut, decoderPosIn,
        decoderNegIn, txAlarmCmd, rxDataOut, encoderDataIn, frameGenSyncIn,
        overheadExternalEn, errInsertEn, txFrameSync, txOverheadClockOut,
        txGappedClockOut, txClockFromRx, busRxValid, busRxByte, cellTxValid,
        cellTxByte, cdRxValid, cdRxByte};
      check(64'(act & e[87:44]), 64'(e[43:0] & e[87:44]));
    end
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] addr,
      input logic [7:0] wdata, output logic [7:0] rdata, output int n);
    n = 0;
    @(posedge clock);
    avs_address <= addr;
    avs_writedata <= {24'h0, wdata};
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 2000);
    rdata = avs_readdata[7:0];
    if (n >= 2000) fails++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end

  initial begin
    logic [7:0] want [6];
    repeat (10) @(posedge clock);
    check(64'({avs_waitrequest, overheadExternalEn}), 64'h3);
    rst <= 1'b0;
    bus(1'b1, 8'h10, 8'h5a, rd, lat);
    foreach (regAddr[i]) begin
      bus(1'b0, regAddr[i], 8'h00, rd, lat);
      check(64'(rd), 64'(`REG_RESET));
    end
    $display("reset values done");
    for (int i = 0; i < 12; i++) begin
      {pm, ce, fm, ff} = cfgTab[i];
      slow <= i[0];
      rxPosRailIn <= 1'($random(seed));
      rxNegRailIn <= 1'($random(seed));
      bus(1'b1, `ADDR_PORT_MODE, pm, rd, lat);
      bus(1'b1, `ADDR_TX_CELL_INT_EN, ce, rd, lat);
      bus(1'b1, `ADDR_FRAMER_MODE, fm, rd, lat);
      bus(1'b1, `ADDR_FRAMER_FEATURE, ff, rd, lat);
      check(64'(lat >= `SETTLE_CYCLES - 2 && lat <= `SETTLE_CYCLES + 4),
        64'h1);
      want = '{pm, ce, fm, ff, {1'b0, pm[6:5], fm[1], ff[5:4], fm[0], 1'b0},
        8'h00};
      foreach (regAddr[j]) begin
        bus(1'b0, regAddr[j], 8'h00, rd, lat);
        check(64'(rd), 64'(want[j]));
      end
      @(posedge clock);
      streamOn <= 1'b1;
      repeat (40) @(posedge clock);
      streamOn <= 1'b0;
      repeat (3) @(posedge clock);
      $display("loop setting %0d done", i);
    end
    conclude();
  end
endmodule
